// file: design/pit_device.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_device
  import pit_pkg::*;
#(
  parameter int unsigned CNT_W = `PIT_CNT_W,
  parameter int unsigned PRESCALE = `PIT_PRESCALE
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link from the host
  pit_link_if.dev link,
  // interrupt pins, index 1 is highest priority
  input wire logic [`PIT_NUM_IRQ:1] irq_pin_n,
  // two-way io ports
  input wire logic [`PIT_NUM_PORT-1:0] port_in,
  output logic [`PIT_NUM_PORT-1:0] port_out,
  output logic [`PIT_NUM_PORT-1:0] port_oe_n
);

  localparam int unsigned PIN_W = `PIT_NUM_IRQ + `PIT_NUM_PORT;
  localparam int unsigned PS_W = $clog2(PRESCALE);

  logic rst;
  logic [PIN_W-1:0] pin_q;
  logic [`PIT_NUM_IRQ:1] irq_lvl_n;
  logic [`PIT_NUM_PORT-1:0] port_lvl;
  logic mode;
  logic [`PIT_NUM_IRQ:1] mask;
  logic [CNT_W-1:0] start;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] latch;
  logic [PS_W-1:0] presc;
  logic timer_irq;
  logic timer_en;
  logic tick;
  logic wrap;
  logic mode_wr;
  logic clk_wr;
  logic mask_wr;
  logic port_wr;
  logic soft_port_reset;
  logic [3:0] clk_idx;
  logic [CNT_W-1:0] next_start;
  logic [`PIT_NUM_IRQ:1] active;
  logic any_active;
  pit_level_code_type next_code;
  logic next_rd_bit;
  logic req_n;
  pit_level_code_type code;
  logic rd_valid_q;
  logic rd_bit_q;
  pit_bit_addr_type a;

  // the clear pin is logic on this clock, so no synchroniser
  assign rst = srst || !link.power_up_clear_n;
  assign a = link.bus_addr;

  pit_sync3
  #(
    .W(PIN_W),
    .INIT({PIN_W{1'b1}})
  )
  u_pin_sync
  (
    .clk(clk),
    .srst(srst),
    .d({port_in, irq_pin_n}),
    .q(pin_q)
  );

  assign irq_lvl_n = pin_q[`PIT_NUM_IRQ-1:0];
  assign port_lvl = pin_q[PIN_W-1:`PIT_NUM_IRQ];

  // bit write decode
  assign mode_wr = link.bus_wr && (a == `PIT_BIT_MODE);
  assign clk_wr = link.bus_wr && mode && (a >= `PIT_BIT_CLK_LO) && (a <= `PIT_BIT_CLK_HI);
  assign mask_wr = link.bus_wr && !mode && (a >= `PIT_BIT_CLK_LO) && (a <= `PIT_BIT_REQ);
  assign port_wr = link.bus_wr && a[4];
  assign soft_port_reset = link.bus_wr && mode && (a == `PIT_BIT_REQ) && link.bus_wdat;
  assign clk_idx = 4'(a - `PIT_BIT_CLK_LO);

  assign timer_en = (start != '0);
  assign tick = timer_en && (presc == PS_W'(PRESCALE - 1));
  assign wrap = tick && (count <= CNT_W'(1));

  always_comb
  begin
    next_start = start;
    next_start[clk_idx] = link.bus_wdat;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode <= 1'b0;
    else if (mode_wr)
      mode <= link.bus_wdat;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      latch <= '0;
    else if (mode_wr && link.bus_wdat)
      latch <= count;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      start <= '0;
    else if (clk_wr)
      start <= next_start;
  end

  // restarts also clear the prescaler, so every interval is whole
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= '0;
      presc <= '0;
    end
    else if (clk_wr)
    begin
      count <= next_start;
      presc <= '0;
    end
    else if (mode_wr && !link.bus_wdat)
    begin
      count <= start;
      presc <= '0;
    end
    else if (timer_en)
    begin
      presc <= tick ? '0 : presc + PS_W'(1);
      if (wrap)
        count <= start;
      else if (tick)
        count <= count - CNT_W'(1);
    end
  end

  // a wrap in the same cycle as the clearing write keeps the flag
  always_ff @(posedge clk)
  begin
    if (rst)
      timer_irq <= 1'b0;
    else if (wrap)
      timer_irq <= 1'b1;
    else if (mask_wr && (a == `PIT_BIT_CLK_MASK))
      timer_irq <= 1'b0;
    else if (!timer_en)
      timer_irq <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mask <= '0;
    else if (mask_wr)
      mask[a[3:0]] <= link.bus_wdat;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_out <= '0;
      port_oe_n <= '1;
    end
    else if (soft_port_reset)
      port_oe_n <= '1;
    else if (port_wr)
    begin
      port_out[a[3:0]] <= link.bus_wdat;
      port_oe_n[a[3:0]] <= 1'b0;
    end
  end

  // priority: lowest index wins
  always_comb
  begin
    active = mask & ~irq_lvl_n;
    active[3] = timer_en ? (mask[3] && timer_irq) : (mask[3] && !irq_lvl_n[3]);
    any_active = 1'b0;
    next_code = `PIT_CODE_IDLE;
    for (int i = `PIT_NUM_IRQ; i >= 1; i--)
    begin
      if (active[i])
      begin
        any_active = 1'b1;
        next_code = 4'(i);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_n <= 1'b1;
      code <= `PIT_CODE_RESET;
    end
    else
    begin
      req_n <= !any_active;
      code <= next_code;
    end
  end

  // read mux
  always_comb
  begin
    if (a == `PIT_BIT_MODE)
      next_rd_bit = mode;
    else if (a[4])
      next_rd_bit = port_lvl[a[3:0]];
    else if (mode && (a == `PIT_BIT_REQ))
      next_rd_bit = !req_n;
    else if (mode)
      next_rd_bit = latch[clk_idx];
    else
      next_rd_bit = irq_lvl_n[a[3:0]];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_valid_q <= 1'b0;
      rd_bit_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= link.bus_rd;
      if (link.bus_rd)
        rd_bit_q <= next_rd_bit;
    end
  end

  assign link.rd_valid = rd_valid_q;
  assign link.rd_bit = rd_bit_q;
  assign link.irq_request_n = req_n;
  assign link.irq_level_code = code;

endmodule

`default_nettype wire

// file: design/pit_params.svh
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

// serial bit bus geometry
`define PIT_ADDR_W 5
`define PIT_CNT_W 14
`define PIT_NUM_IRQ 15
`define PIT_NUM_PORT 16

// bit addresses on the serial bus
`define PIT_BIT_MODE 5'h00
`define PIT_BIT_CLK_LO 5'h01
`define PIT_BIT_CLK_HI 5'h0e
`define PIT_BIT_CLK_MASK 5'h03
`define PIT_BIT_REQ 5'h0f

// timing counts
`define PIT_PRESCALE 64
`define PIT_PUC_CYCLES 2

// host register offsets and fields
`define PIT_REG_CMD 12'h000
`define PIT_REG_STATUS 12'h004
`define PIT_REG_RESET 12'h008
`define PIT_CMD_ADDR_LSB 0
`define PIT_CMD_WRITE_BIT 8
`define PIT_CMD_WDAT_BIT 16

// reset and idle level codes
`define PIT_CODE_RESET 4'h0
`define PIT_CODE_IDLE 4'hf

`endif

// file: design/pit_pkg.sv
package pit_pkg;

  typedef enum logic [1:0]
  {
    PIT_HOST_IDLE = 2'b01,
    PIT_HOST_RD_WAIT = 2'b10
  } pit_host_state_type;

  typedef logic [4:0] pit_bit_addr_type;
  typedef logic [3:0] pit_level_code_type;

endpackage

// file: design/pit_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pit_link_if;
  logic [4:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic bus_wdat;
  logic rd_valid;
  logic rd_bit;
  logic irq_request_n;
  logic [3:0] irq_level_code;
  logic power_up_clear_n;

  modport dev
  (
    input bus_addr, bus_wr, bus_rd, bus_wdat, power_up_clear_n,
    output rd_valid, rd_bit, irq_request_n, irq_level_code
  );

  modport host
  (
    output bus_addr, bus_wr, bus_rd, bus_wdat, power_up_clear_n,
    input rd_valid, rd_bit, irq_request_n, irq_level_code
  );
endinterface

`default_nettype wire

// file: design/pit_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module pit_sync3
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds only s2; a bit moves once s2 and s3 agree
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (q & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
    end
  end

endmodule

`default_nettype wire

// file: design/pit_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_host
  import pit_pkg::*;
#(
  parameter int unsigned PUC_CYCLES = `PIT_PUC_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the timer
  pit_link_if.host link
);

  pit_host_state_type state;
  logic [1:0] puc_cnt;
  logic puc_n;
  logic busy;
  logic done;
  logic rsp_bit;
  logic req_n_q;
  logic [3:0] code_q;
  logic [4:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic wdat_q;
  logic apb_wr;
  logic cmd_wr;
  logic reset_wr;
  logic launch;

  assign apb_wr = psel && penable && pwrite;
  assign cmd_wr = apb_wr && (paddr == `PIT_REG_CMD);
  assign reset_wr = apb_wr && (paddr == `PIT_REG_RESET) && pwdata[0];
  // commands while the clear pulse runs would be lost, so they are dropped
  assign launch = cmd_wr && !busy && puc_n;

  assign link.bus_addr = addr_q;
  assign link.bus_wr = wr_q;
  assign link.bus_rd = rd_q;
  assign link.bus_wdat = wdat_q;
  assign link.power_up_clear_n = puc_n;

  // power-up clear held low for the full count
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      puc_cnt <= 2'(PUC_CYCLES);
      puc_n <= 1'b0;
    end
    else if (reset_wr)
    begin
      puc_cnt <= 2'(PUC_CYCLES);
      puc_n <= 1'b0;
    end
    else
    begin
      if (puc_cnt != 2'h0)
      begin
        puc_cnt <= puc_cnt - 2'h1;
      end
      puc_n <= (puc_cnt <= 2'h1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addr_q <= 5'h00;
      wdat_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= launch && pwdata[`PIT_CMD_WRITE_BIT];
      rd_q <= launch && !pwdata[`PIT_CMD_WRITE_BIT];
      if (launch)
      begin
        addr_q <= pwdata[`PIT_CMD_ADDR_LSB +: 5];
        wdat_q <= pwdata[`PIT_CMD_WDAT_BIT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= PIT_HOST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      rsp_bit <= 1'b0;
    end
    else
    begin
      case (state)
        PIT_HOST_IDLE:
        begin
          if (launch && !pwdata[`PIT_CMD_WRITE_BIT])
          begin
            state <= PIT_HOST_RD_WAIT;
            busy <= 1'b1;
            done <= 1'b0;
          end
          else if (launch)
          begin
            done <= 1'b1;
          end
        end
        PIT_HOST_RD_WAIT:
        begin
          if (link.rd_valid)
          begin
            state <= PIT_HOST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            rsp_bit <= link.rd_bit;
          end
        end
        default:
        begin
          state <= PIT_HOST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      req_n_q <= 1'b1;
      code_q <= `PIT_CODE_RESET;
    end
    else
    begin
      req_n_q <= link.irq_request_n;
      code_q <= link.irq_level_code;
    end
  end

  // read data latched in the setup phase, so pready can stay high
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == `PIT_REG_STATUS)
        begin
          prdata <= {23'h000000, code_q, ~req_n_q, ~puc_n, rsp_bit, done, busy};
        end
        else
        begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: verif/pit_link_checker.sv
`timescale 1ns/1ps
`default_nettype none

module pit_link_checker
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link from the host
  input wire logic [4:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_wdat,
  input wire logic power_up_clear_n,
  // link from the timer
  input wire logic rd_valid,
  input wire logic rd_bit,
  input wire logic irq_request_n,
  input wire logic [3:0] irq_level_code
);
  logic mode_q;
  logic [2:0] settle;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // shadow of the mode bit, cleared like the timer
  always_ff @(posedge clk)
  begin
    if (srst || !power_up_clear_n)
      mode_q <= 1'b0;
    else if (bus_wr && bus_addr == 5'h00)
      mode_q <= bus_wdat;
  end

  // outputs trail the clear by a few cycles
  always_ff @(posedge clk)
  begin
    if (srst || !power_up_clear_n)
      settle <= 3'h0;
    else if (settle != 3'h4)
      settle <= settle + 3'h1;
  end

  sequence s_clear;
    !power_up_clear_n ##1 !power_up_clear_n;
  endsequence

  sequence s_req_read;
    (bus_rd && bus_addr == 5'h0f && mode_q) ##1 $stable(irq_request_n);
  endsequence

  a_read_answer:
    assert property (bus_rd |=> rd_valid) else $error("read not answered");
  a_no_stray_valid:
    assert property (!bus_rd |=> !rd_valid) else $error("answer without read");
  a_mode_readback:
    assert property (bus_rd && bus_addr == 5'h00 |=> rd_bit == $past(mode_q)) else $error("mode bit wrong");
  a_req_readback:
    assert property (s_req_read |-> rd_bit == !irq_request_n) else $error("request bit wrong");
  a_clear_outputs:
    assert property (s_clear |=> irq_request_n && irq_level_code == 4'h0) else $error("clear outputs wrong");
  a_idle_code:
    assert property (settle == 3'h4 && irq_request_n |-> irq_level_code == 4'hf) else $error("idle code wrong");
  a_req_has_code:
    assert property (!irq_request_n |-> irq_level_code != 4'hf && irq_level_code != 4'h0)
      else $error("request without code");
  a_mask3_clears:
    assert property (bus_wr && bus_addr == 5'h03 && !bus_wdat && !mode_q |-> ##[1:4] irq_level_code != 4'h3)
      else $error("level three not cleared");
  a_clear_width:
    assert property ($fell(power_up_clear_n) |=> !power_up_clear_n) else $error("clear pulse too short");
endmodule

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module testbench
  import pit_pkg::*;
;
  localparam logic [13:0] START = 14'h0064;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic [15:1] irq_pin_n = 15'h7fff;
  logic [15:0] port_out;
  logic [15:0] port_oe_n;
  logic [31:0] q;
  logic [13:0] v;
  logic [13:0] lat;
  logic b;
  int mismatches = 0;
  int checked = 0;
  int n;

  always #2.5 clk = ~clk;

  pit_link_if lk ();
  pit_host pit_host_i (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
    .link(lk));
  // short prescale keeps the intervals to a few hundred cycles
  pit_device #(.PRESCALE(4)) pit_device_i (.clk, .srst, .link(lk), .irq_pin_n, .port_in(16'h0000), .port_out,
    .port_oe_n);
  pit_link_checker pit_link_checker_i (.clk, .srst, .bus_addr(lk.bus_addr), .bus_wr(lk.bus_wr),
    .bus_rd(lk.bus_rd), .bus_wdat(lk.bus_wdat), .power_up_clear_n(lk.power_up_clear_n), .rd_valid(lk.rd_valid),
    .rd_bit(lk.rd_bit), .irq_request_n(lk.irq_request_n), .irq_level_code(lk.irq_level_code));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
      begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic cmp_in(input string nm, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("wrong value %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask

  task automatic give_up();
    mismatches++;
    $display("wrong value wait exp done got timeout");
    stop_test();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 40);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t == 40)
      give_up();
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int t;
    t = 0;
    do
    begin
      apb(1'b0, `PIT_REG_STATUS, 32'h0);
      t++;
    end
    while ((q & m) !== e && t < 20);
    if (t == 20)
      give_up();
  endtask

  task automatic link_op(input logic w, input logic [4:0] a, input logic d);
    apb(1'b1, `PIT_REG_CMD, {15'h0, d, 7'h0, w, 3'h0, a});
    poll(32'h3, 32'h2);
    b = q[2];
  endtask

  task automatic watch(input int lim, input bit must);
    n = 0;
    while (lk.irq_request_n !== 1'b0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (must && n == lim)
      give_up();
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    poll(32'h8, 32'h0);
    link_op(1'b0, 5'h00, 1'b0);
    cmp_val("mode", 32'h0, {31'h0, b});
    cmp_val("idle", 32'h1f, {27'h0, lk.irq_request_n, lk.irq_level_code});
    cmp_val("oe", 32'hffff, {16'h0, port_oe_n});
    $display("reset test done");
    link_op(1'b1, 5'h03, 1'b1);
    link_op(1'b1, 5'h00, 1'b1);
    for (int i = 1; i <= 14; i++)
      link_op(1'b1, 5'(i), START[i-1]);
    watch(600, 1'b1);
    cmp_in("interval", 394, 408, n);
    cmp_val("code3", 32'h3, {28'h0, lk.irq_level_code});
    link_op(1'b0, 5'h0f, 1'b0);
    cmp_val("req bit", 32'h1, {31'h0, b});
    link_op(1'b0, 5'h00, 1'b0);
    cmp_val("mode1", 32'h1, {31'h0, b});
    $display("timer test done");
    // pin three held active must not mask the restart
    irq_pin_n[3] <= 1'b0;
    link_op(1'b1, 5'h00, 1'b0);
    link_op(1'b1, 5'h03, 1'b1);
    watch(600, 1'b1);
    cmp_in("restart", 388, 402, n);
    cmp_val("code3b", 32'h3, {28'h0, lk.irq_level_code});
    $display("restart test done");
    // request only polled, never serviced, while the timer is touched
    link_op(1'b1, 5'h00, 1'b1);
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 1; i <= 14; i++)
      begin
        link_op(1'b0, 5'(i), 1'b0);
        v[i-1] = b;
      end
      if (r == 0)
        lat = v;
    end
    cmp_in("latch", 96, 100, int'(lat));
    cmp_val("latch hold", {18'h0, lat}, {18'h0, v});
    $display("latch test done");
    link_op(1'b1, 5'h10, 1'b1);
    cmp_val("port0", 32'h2, {30'h0, port_out[0], port_oe_n[0]});
    link_op(1'b1, 5'h0f, 1'b1);
    cmp_val("ports in", 32'hffff, {16'h0, port_oe_n});
    $display("port test done");
    irq_pin_n[3] <= 1'b1;
    link_op(1'b1, 5'h03, 1'b0);
    link_op(1'b1, 5'h06, 1'b0);
    link_op(1'b1, 5'h07, 1'b0);
    link_op(1'b1, 5'h00, 1'b0);
    link_op(1'b1, 5'h03, 1'b1);
    watch(600, 1'b0);
    cmp_val("disabled", 32'd600, n);
    $display("disable test done");
    link_op(1'b1, 5'h03, 1'b0);
    irq_pin_n[5] <= 1'b0;
    // pin level needs the synchroniser's edges before it can be read
    repeat (4) @(posedge clk);
    link_op(1'b0, 5'h05, 1'b0);
    cmp_val("pin5", 32'h0, {31'h0, b});
    link_op(1'b0, 5'h06, 1'b0);
    cmp_val("pin6", 32'h1, {31'h0, b});
    link_op(1'b1, 5'h05, 1'b1);
    watch(40, 1'b1);
    cmp_val("code5", 32'h5, {28'h0, lk.irq_level_code});
    apb(1'b1, `PIT_REG_RESET, 32'h1);
    poll(32'h8, 32'h0);
    cmp_val("masks off", 32'h1, {31'h0, lk.irq_request_n});
    apb(1'b0, 12'h0fc, 32'h0);
    cmp_val("unmapped", 32'h0, q);
    $display("pin test done");
    stop_test();
  end
endmodule

`default_nettype wire
